// >>> inc/ebpin_pkg.sv
// Package: constants and carrier types of the external bus pin block
//**********************************************************************
// How it works
// - Low address lines hold address bits 0-15 for the whole external cycle.
// - High address lines hold bits 16-20 for the whole cycle, 2 Mbyte space.
// - Internal address is 24 bits; only the low 21 reach the pins.
// - Reset fetch address is FF2080H internal, 1F2080H external execution.
// - High address pins fall back to extended port bits 4:0 when high addressing is not enabled.
// - Shared address/data pins return to port use whenever no access runs.
// - 16-bit multiplexed: address on all sixteen lines, then data second half.
// - 8-bit multiplexed: upper lines keep address 8-15; lower lines address then data.
// - 16-bit demultiplexed: all sixteen shared lines carry data the whole cycle.
// - 8-bit demultiplexed: low byte data; upper lines show internal bus high byte.
// - Lower shared lines pair with port three, upper with port four.
// - Address latch strobe is high only in external cycles, never internal.
// - Strobe marks cycle start while a valid address is on the pins.
// - Strobe pin falls back to port five bit zero when not configured.
//**********************************************************************
package ebpin_pkg;

   //**********************************************************************
   // Address layout
   //**********************************************************************
   localparam int          INT_ADDR_W    = 24;
   localparam int          EXT_ADDR_W    = 21;
   localparam int          DATA_W        = 16;
   localparam int          HIGH_ADDR_LSB = 16;
   localparam int          HIGH_ADDR_W   = 5;
   localparam logic [23:0] FETCH_INT     = 24'hFF2080;
   localparam logic [23:0] FETCH_EXT     = 24'h1F2080;

   //**********************************************************************
   // Timing: half-cycle lengths in ns, cycle counts rounded up at 4 ns
   //**********************************************************************
   localparam int          CLK_PS        = 4000;
   localparam int          ADDR_PHASE_NS = 8;
   localparam int          DATA_PHASE_NS = 12;
   localparam int          ADDR_CYC      = (ADDR_PHASE_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int          DATA_CYC      = (DATA_PHASE_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int          CNT_W         = 4;

   //**********************************************************************
   // Carrier types
   //**********************************************************************
   typedef struct packed {
      logic [INT_ADDR_W-1:0] addr;
      logic                  write;
      logic [DATA_W-1:0]     wdata;
      logic                  bus16;
      logic                  mux;
   } ebpin_req_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ADDR = 3'b010,
      ST_DATA = 3'b100
   } ebpin_state_e;

endpackage

// >>> rtl/ebpin_top.sv
// Module: external bus pin driver with address, shared address/data and strobe pins
`timescale 1ns/1ps
module ebpin_top
   import ebpin_pkg::*;
(
   input  wire logic                   CORE_CLK_I,
   input  wire logic                   SRST_I,
   input  wire logic                   REQ_VALID_I,
   input  wire ebpin_req_s             REQ_I,
   output logic                        REQ_READY_O,
   output logic                        DONE_O,
   output logic [DATA_W-1:0]           RD_DATA_O,
   output logic                        BUSY_O,
   input  wire logic [7:0]             IBUS_HIGH_I,
   input  wire logic                   EXT_EXEC_N_I,
   output logic [INT_ADDR_W-1:0]       FETCH_ADDR_O,
   input  wire logic                   HIGH_ADDR_EN_I,
   input  wire logic                   STROBE_EN_I,
   output logic [15:0]                 LOW_ADDRESS_LINES_O,
   output logic [HIGH_ADDR_W-1:0]      HIGH_ADDRESS_LINES_O,
   output logic [HIGH_ADDR_W-1:0]      HIGH_ADDRESS_LINES_OE_O,
   input  wire logic [HIGH_ADDR_W-1:0] EXTENDED_PORT_OUT_I,
   input  wire logic [HIGH_ADDR_W-1:0] EXTENDED_PORT_OE_I,
   input  wire logic [DATA_W-1:0]      SHARED_ADDR_DATA_LINES_I,
   output logic [DATA_W-1:0]           SHARED_ADDR_DATA_LINES_O,
   output logic [DATA_W-1:0]           SHARED_ADDR_DATA_LINES_OE_O,
   output logic [DATA_W-1:0]           SHARED_PORT_IN_O,
   input  wire logic [7:0]             PORT_THREE_BITS_OUT_I,
   input  wire logic [7:0]             PORT_THREE_BITS_OE_I,
   input  wire logic [7:0]             PORT_FOUR_BITS_OUT_I,
   input  wire logic [7:0]             PORT_FOUR_BITS_OE_I,
   output logic                        ADDR_STROBE_O,
   output logic                        ADDR_STROBE_OE_O,
   input  wire logic                   PORT_FIVE_BIT_ZERO_OUT_I,
   input  wire logic                   PORT_FIVE_BIT_ZERO_OE_I
);

   //**********************************************************************
   // Pin synchronisers
   //**********************************************************************
   logic [DATA_W-1:0] ad_s1_r;
   logic [DATA_W-1:0] ad_s2_r;
   logic              ext_s1_r;
   logic              ext_s2_r;

   always_ff @(posedge CORE_CLK_I) begin
      ad_s1_r  <= SHARED_ADDR_DATA_LINES_I;
      ad_s2_r  <= ad_s1_r;
      ext_s1_r <= EXT_EXEC_N_I;
      ext_s2_r <= ext_s1_r;
   end

   assign SHARED_PORT_IN_O = ad_s2_r;

   //**********************************************************************
   // Reset fetch address, strap taken on the first cycle after release
   //**********************************************************************
   logic                  strap_done_r;
   logic [INT_ADDR_W-1:0] fetch_r;

   always_ff @(posedge CORE_CLK_I) begin
      if (SRST_I) begin
         strap_done_r <= 1'b0;
         fetch_r      <= FETCH_INT;
      end else if (!strap_done_r) begin
         strap_done_r <= 1'b1;
         fetch_r      <= ext_s2_r ? FETCH_INT : FETCH_EXT;
      end
   end

   assign FETCH_ADDR_O = fetch_r;

   //**********************************************************************
   // Cycle sequencer
   //**********************************************************************
   ebpin_state_e          state_r;
   ebpin_state_e          state_nxt;
   logic [CNT_W-1:0]      cnt_r;
   logic [CNT_W-1:0]      cnt_nxt;
   logic [EXT_ADDR_W-1:0] addr_r;
   logic [DATA_W-1:0]     wdata_r;
   logic                  write_r;
   logic                  bus16_r;
   logic                  mux_r;
   logic [DATA_W-1:0]     rdata_r;
   logic                  done_r;

   localparam logic [CNT_W-1:0] ADDR_LAST = CNT_W'(ADDR_CYC - 1);
   localparam logic [CNT_W-1:0] DATA_LAST = CNT_W'(DATA_CYC - 1);

   wire take     = REQ_VALID_I && (state_r == ST_IDLE);
   wire addr_end = (state_r == ST_ADDR) && (cnt_r == ADDR_LAST);
   wire data_end = (state_r == ST_DATA) && (cnt_r == DATA_LAST);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r + CNT_W'(1);
      case (state_r)
         ST_IDLE: begin
            cnt_nxt = '0;
            if (take) begin
               state_nxt = ST_ADDR;
            end
         end
         ST_ADDR: begin
            if (addr_end) begin
               state_nxt = ST_DATA;
               cnt_nxt   = '0;
            end
         end
         ST_DATA: begin
            if (data_end) begin
               state_nxt = ST_IDLE;
               cnt_nxt   = '0;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
            cnt_nxt   = '0;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (SRST_I) begin
         state_r <= ST_IDLE;
         cnt_r   <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // Format is frozen at acceptance so a mid-cycle change cannot tear the pins
   always_ff @(posedge CORE_CLK_I) begin
      if (SRST_I) begin
         addr_r  <= '0;
         wdata_r <= '0;
         write_r <= 1'b0;
         bus16_r <= 1'b0;
         mux_r   <= 1'b0;
      end else if (take) begin
         addr_r  <= REQ_I.addr[EXT_ADDR_W-1:0];
         wdata_r <= REQ_I.wdata;
         write_r <= REQ_I.write;
         bus16_r <= REQ_I.bus16;
         mux_r   <= REQ_I.mux;
      end
   end

   // Sampled from the synchronised pins, so read data is the pin level at the first data-half edge, two cycles before the end
   always_ff @(posedge CORE_CLK_I) begin
      if (SRST_I) begin
         rdata_r <= '0;
         done_r  <= 1'b0;
      end else begin
         done_r <= data_end;
         if (data_end && !write_r) begin
            rdata_r <= bus16_r ? ad_s2_r : {8'h00, ad_s2_r[7:0]};
         end
      end
   end

   assign REQ_READY_O = (state_r == ST_IDLE);
   assign BUSY_O      = (state_r != ST_IDLE);
   assign DONE_O      = done_r;
   assign RD_DATA_O   = rdata_r;

   //**********************************************************************
   // Pin selection
   //**********************************************************************
   wire in_addr = (state_r == ST_ADDR);
   wire in_data = (state_r == ST_DATA);
   // Demultiplexed writes own the data lines for the whole cycle, multiplexed ones only after the address half
   wire drive_d = write_r && (in_data || (in_addr && !mux_r));
   wire addr_ph = in_addr && mux_r;

   // Lines hold the last address between cycles; only a new cycle moves them
   assign LOW_ADDRESS_LINES_O = addr_r[15:0];

   assign HIGH_ADDRESS_LINES_O    = HIGH_ADDR_EN_I ? addr_r[EXT_ADDR_W-1:HIGH_ADDR_LSB]
                                                   : EXTENDED_PORT_OUT_I;
   assign HIGH_ADDRESS_LINES_OE_O = HIGH_ADDR_EN_I ? {HIGH_ADDR_W{1'b1}} : EXTENDED_PORT_OE_I;

   wire [7:0] lo_bus = addr_ph ? addr_r[7:0] : wdata_r[7:0];
   wire       lo_oe  = addr_ph || drive_d;

   wire [7:0] hi_bus = bus16_r ? (addr_ph ? addr_r[15:8] : wdata_r[15:8])
                     : (mux_r ? addr_r[15:8] : IBUS_HIGH_I);
   wire       hi_oe  = bus16_r ? (addr_ph || drive_d) : 1'b1;

   assign SHARED_ADDR_DATA_LINES_O    = BUSY_O ? {hi_bus, lo_bus}
                                               : {PORT_FOUR_BITS_OUT_I, PORT_THREE_BITS_OUT_I};
   assign SHARED_ADDR_DATA_LINES_OE_O = BUSY_O ? {{8{hi_oe}}, {8{lo_oe}}}
                                               : {PORT_FOUR_BITS_OE_I, PORT_THREE_BITS_OE_I};

   // Strobe spans the address half; requests here are external cycles only
   assign ADDR_STROBE_O    = STROBE_EN_I ? in_addr : PORT_FIVE_BIT_ZERO_OUT_I;
   assign ADDR_STROBE_OE_O = STROBE_EN_I ? 1'b1 : PORT_FIVE_BIT_ZERO_OE_I;

endmodule

// >>> verif/ebpin_top_sva.sv
// Checker: strobe, address hold and port fallback timing at the pins
`timescale 1ns/1ps
module ebpin_top_sva
   import ebpin_pkg::*;
(
   input wire logic                   CORE_CLK_I,
   input wire logic                   SRST_I,
   input wire logic                   REQ_VALID_I,
   input wire ebpin_req_s             REQ_I,
   input wire logic                   REQ_READY_O,
   input wire logic                   DONE_O,
   input wire logic                   BUSY_O,
   input wire logic                   HIGH_ADDR_EN_I,
   input wire logic                   STROBE_EN_I,
   input wire logic [15:0]            LOW_ADDRESS_LINES_O,
   input wire logic [HIGH_ADDR_W-1:0] HIGH_ADDRESS_LINES_O,
   input wire logic [DATA_W-1:0]      SHARED_ADDR_DATA_LINES_OE_O,
   input wire logic [7:0]             PORT_THREE_BITS_OE_I,
   input wire logic [7:0]             PORT_FOUR_BITS_OE_I,
   input wire logic                   ADDR_STROBE_O,
   input wire logic                   PORT_FIVE_BIT_ZERO_OUT_I
);
   wire take = REQ_VALID_I && REQ_READY_O;
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (SRST_I);
   AST_CYCLE_LEN: assert property (take |=> BUSY_O [*5] ##1 (DONE_O && !BUSY_O))
      else $error("cycle length");
   AST_STB_HALF: assert property (take && STROBE_EN_I |=> ADDR_STROBE_O [*2] ##1 !ADDR_STROBE_O)
      else $error("strobe half");
   AST_STB_IDLE: assert property (STROBE_EN_I && !BUSY_O |-> !ADDR_STROBE_O) else $error("strobe idle");
   AST_STB_PORT: assert property (!STROBE_EN_I |-> ADDR_STROBE_O == PORT_FIVE_BIT_ZERO_OUT_I)
      else $error("strobe port");
   AST_LOW_TAKE: assert property (take |=> LOW_ADDRESS_LINES_O == $past(REQ_I.addr[15:0]))
      else $error("low address");
   AST_LOW_HOLD: assert property (BUSY_O && $past(BUSY_O) |-> $stable(LOW_ADDRESS_LINES_O))
      else $error("low address moved");
   AST_HIGH_TAKE: assert property (take && HIGH_ADDR_EN_I |=>
      HIGH_ADDRESS_LINES_O == $past(REQ_I.addr[20:16])) else $error("high address");
   AST_IDLE_PORT: assert property (!BUSY_O |->
      SHARED_ADDR_DATA_LINES_OE_O == {PORT_FOUR_BITS_OE_I, PORT_THREE_BITS_OE_I}) else $error("idle pins");
endmodule
bind ebpin_top ebpin_top_sva SVA (.*);

// >>> verif/ebpin_mem.sv
// Partner: external memory with an address latch on the strobe
`timescale 1ns/1ps
module ebpin_mem (
   input  wire logic        clk_i,
   input  wire logic        bus16_i,
   input  wire logic        stb_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [15:0] pin_o_i,
   input  wire logic [15:0] pin_oe_i,
   output logic      [15:0] pin_i_o
);
   logic [15:0] mem [logic [15:0]];
   logic [15:0] lat_r, mlat_r, drv_r, flip_r = '0;
   int          cnt_r = 0;
   // Undriven pins toggle, so a stale level never passes for read data
   assign pin_i_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ((cnt_r > 0 && !stb_i) ? drv_r : flip_r));
   always @(posedge clk_i) begin
      flip_r <= ~pin_i_o;
      if (stb_i) begin
         lat_r  <= addr_i;
         mlat_r <= pin_o_i;
         drv_r  <= mem.exists(addr_i) ? mem[addr_i] : addr_i ^ 16'h5A3C;
         cnt_r  <= 3;
      end else if (cnt_r > 0) begin
         cnt_r <= cnt_r - 1;
         if (cnt_r == 1 && pin_oe_i[0]) mem[lat_r] = bus16_i ? pin_o_i : {8'h00, pin_o_i[7:0]};
      end
   end
endmodule

// >>> verif/ebpin_top_tb.sv
// Testbench: random external cycles checked against a pin model
`timescale 1ns/1ps
module ebpin_top_tb;
   import ebpin_pkg::*;
   logic        CORE_CLK_I = 0, SRST_I = 1, REQ_VALID_I = 0, HIGH_ADDR_EN_I = 1, STROBE_EN_I = 1, EXT_EXEC_N_I = 0;
   logic        PORT_FIVE_BIT_ZERO_OUT_I = 0, PORT_FIVE_BIT_ZERO_OE_I = 0, REQ_READY_O, DONE_O, BUSY_O;
   logic        ADDR_STROBE_O, ADDR_STROBE_OE_O;
   ebpin_req_s  REQ_I = '0;
   logic [7:0]  IBUS_HIGH_I = 0, PORT_THREE_BITS_OUT_I = 0, PORT_THREE_BITS_OE_I = 0;
   logic [7:0]  PORT_FOUR_BITS_OUT_I = 0, PORT_FOUR_BITS_OE_I = 0;
   logic [4:0]  EXTENDED_PORT_OUT_I = 0, EXTENDED_PORT_OE_I = 0, HIGH_ADDRESS_LINES_O, HIGH_ADDRESS_LINES_OE_O;
   logic [15:0] LOW_ADDRESS_LINES_O, SHARED_ADDR_DATA_LINES_I, SHARED_ADDR_DATA_LINES_O;
   logic [15:0] SHARED_ADDR_DATA_LINES_OE_O, SHARED_PORT_IN_O, RD_DATA_O;
   logic [23:0] FETCH_ADDR_O;
   int          miscompares = 0, samples_checked = 0;
   logic [15:0] model [logic [15:0]];
   wire  [31:0] shd = {SHARED_ADDR_DATA_LINES_OE_O, SHARED_ADDR_DATA_LINES_O & SHARED_ADDR_DATA_LINES_OE_O};
   always #2 CORE_CLK_I = ~CORE_CLK_I;
   ebpin_top DUT (.*);
   ebpin_mem MEM (.clk_i(CORE_CLK_I), .bus16_i(REQ_I.bus16), .stb_i(ADDR_STROBE_O), .addr_i(LOW_ADDRESS_LINES_O),
                  .pin_o_i(SHARED_ADDR_DATA_LINES_O), .pin_oe_i(SHARED_ADDR_DATA_LINES_OE_O),
                  .pin_i_o(SHARED_ADDR_DATA_LINES_I));
   task automatic give_verdict();
      if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rnd();
      {IBUS_HIGH_I, PORT_THREE_BITS_OUT_I, PORT_THREE_BITS_OE_I, PORT_FOUR_BITS_OUT_I} = $urandom;
      {PORT_FOUR_BITS_OE_I, EXTENDED_PORT_OUT_I, EXTENDED_PORT_OE_I, PORT_FIVE_BIT_ZERO_OUT_I,
       PORT_FIVE_BIT_ZERO_OE_I} = 20'($urandom);
   endtask
   // Expected {enable, driven level} of the shared pins in the address or data half
   function automatic logic [31:0] pins(input logic adr);
      logic [7:0] le, ue;
      le = REQ_I.write ? 8'hFF : 8'h00;
      ue = REQ_I.bus16 ? le : 8'hFF;
      if (REQ_I.mux && adr) return {16'hFFFF, REQ_I.addr[15:0]};
      return {ue, le, ue & (REQ_I.bus16 ? REQ_I.wdata[15:8] : REQ_I.mux ? REQ_I.addr[15:8] : IBUS_HIGH_I),
              le & REQ_I.wdata[7:0]};
   endfunction
   task automatic xfer();
      int          n;
      logic [15:0] a, e;
      REQ_I.addr = 24'($urandom);
      REQ_I.wdata = 16'($urandom);
      {REQ_I.write, REQ_I.bus16, REQ_I.mux} = 3'($urandom);
      rnd();
      a = REQ_I.addr[15:0];
      REQ_VALID_I = 1;
      for (n = 0; REQ_READY_O !== 1'b1; n++) begin
         if (n == 20) begin
            miscompares++;
            give_verdict();
         end
         @(negedge CORE_CLK_I);
      end
      @(negedge CORE_CLK_I);
      REQ_VALID_I = 0;
      chk("low", a, LOW_ADDRESS_LINES_O);
      chk("high", REQ_I.addr[20:16], HIGH_ADDRESS_LINES_O);
      chk("high oe", 5'h1F, HIGH_ADDRESS_LINES_OE_O);
      chk("strobe", 1, ADDR_STROBE_O);
      chk("strobe oe", 1, ADDR_STROBE_OE_O);
      chk("addr half", pins(1), shd);
      repeat (2) @(negedge CORE_CLK_I);
      if (REQ_I.mux) chk("latch", a, MEM.mlat_r);
      chk("strobe", 0, ADDR_STROBE_O);
      chk("data half", pins(0), shd);
      repeat (3) @(negedge CORE_CLK_I);
      e = model.exists(a) ? model[a] : a ^ 16'h5A3C;
      if (!REQ_I.bus16) e[15:8] = 8'h00;
      chk("done", 1, DONE_O);
      if (REQ_I.write) model[a] = REQ_I.bus16 ? REQ_I.wdata : {8'h00, REQ_I.wdata[7:0]};
      else chk("rdata", e, RD_DATA_O);
   endtask
   initial begin
      void'($urandom(48));
      repeat (6) @(negedge CORE_CLK_I);
      SRST_I = 0;
      repeat (2) @(negedge CORE_CLK_I);
      chk("fetch", 24'h1F2080, FETCH_ADDR_O);
      SRST_I = 1;
      EXT_EXEC_N_I = 1;
      repeat (6) @(negedge CORE_CLK_I);
      SRST_I = 0;
      repeat (2) @(negedge CORE_CLK_I);
      chk("fetch", 24'hFF2080, FETCH_ADDR_O);
      repeat (60) xfer();
      HIGH_ADDR_EN_I = 0;
      STROBE_EN_I = 0;
      repeat (4) begin
         rnd();
         @(negedge CORE_CLK_I);
         chk("extended_port", EXTENDED_PORT_OUT_I, HIGH_ADDRESS_LINES_O);
         chk("extended_port oe", EXTENDED_PORT_OE_I, HIGH_ADDRESS_LINES_OE_O);
         chk("p5", PORT_FIVE_BIT_ZERO_OUT_I, ADDR_STROBE_O);
         chk("p5 oe", PORT_FIVE_BIT_ZERO_OE_I, ADDR_STROBE_OE_O);
         chk("idle", {PORT_FOUR_BITS_OE_I, PORT_THREE_BITS_OE_I, PORT_FOUR_BITS_OUT_I & PORT_FOUR_BITS_OE_I,
             PORT_THREE_BITS_OUT_I & PORT_THREE_BITS_OE_I}, shd);
      end
      // Ports drive every shared pin; their levels come back through the two-stage synchroniser
      {PORT_FOUR_BITS_OUT_I, PORT_THREE_BITS_OUT_I} = 16'($urandom);
      {PORT_FOUR_BITS_OE_I, PORT_THREE_BITS_OE_I} = 16'hFFFF;
      repeat (3) @(negedge CORE_CLK_I);
      chk("port in", {PORT_FOUR_BITS_OUT_I, PORT_THREE_BITS_OUT_I}, SHARED_PORT_IN_O);
      give_verdict();
   end
endmodule
